// >>> deser_pkg.sv
// Constants, register map and state types of the link deserializer.
// Assumes one 25 MHz system clock that also serves as the serial bit clock.
// Functional notes
// - Video word: 20 bits LSB first, two overhead bits, 18 symbols.
// - Control word: bit0 overhead, C0-C4 tripled in 1-15, C5-C8 in 16-19.
// - Video decode uses both overhead bits; control uses bit0 only.
// - Control bits 0 to 4 come from a two-of-three majority vote.
// - Control bits 5 to 8 are taken from their single bit, no vote.
// - Phase flag high with video words, low with control words.
// - Idle line: outputs low, lock high, clock output follows reference.
// - Range select 00..11 picks the band; upper two bands use fast edges.
// - Power-down low tristates outputs and halts PLL; release relocks.
// - Leaving power-down: lock high, outputs low, clock is reference.
// - Reference lock: 16,928 cycles, or 33,600 on the spread variant.
// - Then find transition word, drive lock low, output recovered clock.
// - Spread variant waits 288 further parallel clock cycles before dropping lock.
// - Clock source switches stretch the clock pulse, never glitch.
// - No transition word in 2^22 parallel clocks: lock high, outputs low, retry.
// - Plain variant latency is a fixed pipeline of a few bit periods.
// - Spread variant latency varies with modulation within its bounds; here it uses the same fixed one-word pipeline as the plain variant.
// - Spread select high gives 4 percent spread, low gives 2 percent.
// - Spread modulation period is 1024 parallel clock cycles.
// - Spread change holds data low and invalid for 32,000 bit periods.
// - Control outputs change only in control phase, video only in video.
package deser_pkg;
  localparam int          WORD_BITS       = 20;
  localparam int          VIDEO_BITS      = 18;
  localparam int          CTRL_BITS       = 9;
  localparam int          VOTED_BITS      = 5;
  localparam int          HALF_WORD       = 10;
  localparam int          REF_LOCK_PLAIN  = 16928;
  localparam int          REF_LOCK_SPREAD = 33600;
  localparam int          SEARCH_TIMEOUT  = 4194304;
  localparam int          SS_WAIT_CYC     = 288;
  localparam int          SPREAD_HOLD_CYC = 32000;
  localparam int          MOD_PERIOD      = 1024;
  localparam int          NOINPUT_CYC     = 64;
  localparam logic [19:0] TRANS_WORD_DEF  = 20'hFFC00;
  // Register offsets
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STATUS_OFS      = 8'h04;
  // Control fields
  localparam int          CTRL_PD_N_BIT   = 0;
  localparam int          CTRL_RNG_LSB    = 1;
  localparam int          CTRL_SS_BIT     = 3;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  // Status fields
  localparam int          ST_LOCK_N_BIT   = 0;
  localparam int          ST_IDLE_BIT     = 1;
  localparam int          ST_PHASE_BIT    = 2;
  localparam int          ST_STATE_LSB    = 4;
  localparam int          ST_SPREAD_BIT   = 7;

  typedef enum logic [2:0] {
    LK_OFF,
    LK_REF,
    LK_SEARCH,
    LK_SS_WAIT,
    LK_LOCKED,
    LK_SS_HOLD
  } lock_state_e;
endpackage

// >>> link_deser.sv
// Receive side of the DC-balanced serial video link.
// Serial bits arrive one per system clock; the reference clock is a pin
// sampled into the system clock domain. Registers on classic Wishbone.
`timescale 1ns/100ps
module link_deser
  import deser_pkg::*;
#(
  parameter bit          SPREAD_VARIANT = 1'b0,
  parameter int unsigned REF_LOCK_CYC   = SPREAD_VARIANT ? REF_LOCK_SPREAD
                                                         : REF_LOCK_PLAIN,
  parameter int unsigned TIMEOUT_CYC    = SEARCH_TIMEOUT,
  parameter int unsigned HOLD_CYC       = SPREAD_HOLD_CYC,
  parameter logic [19:0] TRANS_WORD     = TRANS_WORD_DEF
) (
  // Clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        ARST_N_IN,
  // Wishbone slave
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  // Serial link and reference
  input  wire logic        SERIAL_DATA_IN,
  input  wire logic        LOCAL_REF_CLK_IN,
  // Parallel outputs
  output logic      [17:0] VIDEO_WORD_OUT,
  output logic      [8:0]  CTRL_WORD_OUT,
  output logic             PHASE_FLAG_OUT,
  output logic             LOCK_N_OUT,
  output logic             PCLK_OUT,
  output logic             DATA_OE_OUT,
  output logic             LOCK_OE_OUT,
  output logic             FAST_EDGE_OUT,
  // Spread modulation
  output logic      [8:0]  SPREAD_TRI_OUT,
  output logic             SPREAD_WIDE_OUT
);

  typedef struct packed {
    logic        ser_s1;
    logic        ser_s2;
    logic        ser_prev;
    logic        ref_s1;
    logic        ref_s2;
    logic        ref_prev;
    logic [19:0] shift;
    logic [4:0]  bitcnt;
    logic [6:0]  idle_cnt;
    logic        no_input;
    lock_state_e st;
    logic [22:0] cnt;
    logic [9:0]  mod_cnt;
    logic [17:0] video;
    logic [8:0]  ctrl;
    logic        phase;
    logic        lock_n;
    logic        pclk;
    logic        use_rec;
    logic        src_prev;
    logic        oe;
    logic        pd_n;
    logic [1:0]  rng;
    logic        ss;
    logic        ss_applied;
    logic        ack;
    logic [31:0] rdat;
  } state_s;

  state_s q;
  state_s d;

  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Overhead bit0 marks the phase; overhead bit1 flips video symbols
  function automatic logic [17:0] dec_video(input logic [19:0] w);
    return w[19:2] ^ {VIDEO_BITS{w[1]}};
  endfunction

  function automatic logic [8:0] dec_ctrl(input logic [19:0] w);
    logic [8:0] c;
    c = '0;
    for (int i = 0; i < VOTED_BITS; i++) begin
      c[i] = maj3(w[1+3*i +: 3]);
    end
    c[8:5] = w[19:16];
    return c;
  endfunction

  logic [19:0] word_now;
  logic        word_tick;
  logic        ref_rise;
  logic        rec_clk;
  logic        want_rec;
  logic        src_clk;
  logic        access;

  always_comb begin
    d         = q;
    word_now  = {q.ser_s2, q.shift[19:1]};
    word_tick = (q.bitcnt == 5'(WORD_BITS - 1));
    ref_rise  = q.ref_s2 & ~q.ref_prev;
    rec_clk   = (q.bitcnt < 5'(HALF_WORD));
    access    = WB_CYC_IN & WB_STB_IN;

    // Synchronisers and edge history
    d.ser_s1   = SERIAL_DATA_IN;
    d.ser_s2   = q.ser_s1;
    d.ser_prev = q.ser_s2;
    d.ref_s1   = LOCAL_REF_CLK_IN;
    d.ref_s2   = q.ref_s1;
    d.ref_prev = q.ref_s2;
    d.shift    = word_now;
    d.bitcnt   = word_tick ? 5'h00 : 5'(q.bitcnt + 5'h01);

    // Activity detector on the serial line
    if (q.ser_s2 != q.ser_prev) begin
      d.idle_cnt = 7'h00;
      d.no_input = 1'b0;
    end else if (q.idle_cnt == 7'(NOINPUT_CYC - 1)) begin
      d.no_input = 1'b1;
    end else begin
      d.idle_cnt = 7'(q.idle_cnt + 7'h01);
    end

    // Wishbone: ack one cycle after the request, writes land on the ack edge
    d.ack = access & ~q.ack;
    if (access & ~q.ack) begin
      d.rdat = 32'h0000_0000;
      if (WB_ADR_IN == CTRL_OFS) begin
        d.rdat[CTRL_PD_N_BIT]           = q.pd_n;
        d.rdat[CTRL_RNG_LSB +: 2]       = q.rng;
        d.rdat[CTRL_SS_BIT]             = q.ss;
      end else if (WB_ADR_IN == STATUS_OFS) begin
        d.rdat[ST_LOCK_N_BIT]           = q.lock_n;
        d.rdat[ST_IDLE_BIT]             = q.no_input;
        d.rdat[ST_PHASE_BIT]            = q.phase;
        d.rdat[ST_STATE_LSB +: 3]       = q.st;
        d.rdat[ST_SPREAD_BIT]           = q.ss_applied;
      end
    end
    if (access & q.ack & WB_WE_IN & WB_SEL_IN[0] &
        (WB_ADR_IN == CTRL_OFS)) begin
      d.pd_n = WB_DAT_IN[CTRL_PD_N_BIT];
      d.rng  = WB_DAT_IN[CTRL_RNG_LSB +: 2];
      d.ss   = WB_DAT_IN[CTRL_SS_BIT];
    end

    // Spread modulation: triangle over 1024 parallel clocks
    if (word_tick) begin
      d.mod_cnt = 10'(q.mod_cnt + 10'h001);
    end

    // Lock sequencer
    d.cnt = q.cnt;
    case (q.st)
      LK_OFF: begin
        if (q.pd_n) begin
          d.st  = LK_REF;
          d.cnt = '0;
        end
      end
      LK_REF: begin
        if (ref_rise) begin
          d.cnt = 23'(q.cnt + 23'h1);
          if (q.cnt == 23'(REF_LOCK_CYC - 1)) begin
            d.st  = LK_SEARCH;
            d.cnt = '0;
          end
        end
      end
      LK_SEARCH: begin
        if (!q.no_input && word_now == TRANS_WORD) begin
          d.bitcnt     = 5'h00;
          d.cnt        = '0;
          d.ss_applied = q.ss;
          d.st         = SPREAD_VARIANT ? LK_SS_WAIT : LK_LOCKED;
        end else if (word_tick) begin
          // Timeout restarts the search with outputs held low
          if (q.cnt == 23'(TIMEOUT_CYC - 1)) begin
            d.cnt = '0;
          end else begin
            d.cnt = 23'(q.cnt + 23'h1);
          end
        end
      end
      LK_SS_WAIT: begin
        if (word_tick) begin
          d.cnt = 23'(q.cnt + 23'h1);
          if (q.cnt == 23'(SS_WAIT_CYC - 1)) begin
            d.st = LK_LOCKED;
          end
        end
      end
      LK_LOCKED: begin
        if (SPREAD_VARIANT && q.ss != q.ss_applied) begin
          d.st         = LK_SS_HOLD;
          d.cnt        = '0;
          d.ss_applied = q.ss;
        end
      end
      LK_SS_HOLD: begin
        d.cnt = 23'(q.cnt + 23'h1);
        if (q.ss != q.ss_applied) begin
          d.cnt        = '0;
          d.ss_applied = q.ss;
        end else if (q.cnt == 23'(HOLD_CYC - 1)) begin
          d.st = LK_LOCKED;
        end
      end
      default: d.st = LK_OFF;
    endcase
    if (q.no_input && q.st inside {LK_SS_WAIT, LK_LOCKED, LK_SS_HOLD}) begin
      d.st  = LK_SEARCH;
      d.cnt = '0;
    end
    if (!q.pd_n) begin
      d.st = LK_OFF;
    end

    // Outputs
    d.oe     = (d.st != LK_OFF);
    d.lock_n = !(d.st inside {LK_LOCKED, LK_SS_HOLD});
    if (d.st != LK_LOCKED) begin
      // Invalid data is driven low: power-up, idle line, timeout, spread hold
      d.video = '0;
      d.ctrl  = '0;
      d.phase = 1'b0;
    end else if (word_tick) begin
      // Fixed one-word pipeline keeps latency constant
      d.phase = word_now[0];
      if (word_now[0]) begin
        d.video = dec_video(word_now);
      end else begin
        d.ctrl = dec_ctrl(word_now);
      end
    end

    // Clock source switch: hold the level, then hand over on an edge of the
    // new source into that level, so that no pulse comes out short
    want_rec   = d.st inside {LK_SS_WAIT, LK_LOCKED, LK_SS_HOLD};
    src_clk    = want_rec ? rec_clk : q.ref_s2;
    d.src_prev = src_clk;
    if (q.use_rec != want_rec) begin
      if (src_clk == q.pclk && q.src_prev != q.pclk) begin
        d.use_rec = want_rec;
      end
    end else begin
      d.pclk = q.use_rec ? rec_clk : q.ref_s2;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      q            <= '0;
      q.st         <= LK_OFF;
      q.lock_n     <= 1'b1;
      q.no_input   <= 1'b1;
      q.pd_n       <= CTRL_RESET[CTRL_PD_N_BIT];
      q.rng        <= CTRL_RESET[CTRL_RNG_LSB +: 2];
      q.ss         <= CTRL_RESET[CTRL_SS_BIT];
    end else begin
      q <= d;
    end
  end

  assign WB_DAT_OUT      = q.rdat;
  assign WB_ACK_OUT      = q.ack;
  assign VIDEO_WORD_OUT  = q.video;
  assign CTRL_WORD_OUT   = q.ctrl;
  assign PHASE_FLAG_OUT  = q.phase;
  assign LOCK_N_OUT      = q.lock_n;
  assign PCLK_OUT        = q.pclk;
  assign DATA_OE_OUT     = q.oe;
  assign LOCK_OE_OUT     = q.oe;
  assign FAST_EDGE_OUT   = q.rng[1];
  // Triangle index scales the offset; wide flag picks 4 or 2 percent
  assign SPREAD_TRI_OUT  = (SPREAD_VARIANT && q.st == LK_LOCKED)
                           ? (q.mod_cnt[9] ? ~q.mod_cnt[8:0] : q.mod_cnt[8:0])
                           : 9'h000;
  assign SPREAD_WIDE_OUT = SPREAD_VARIANT & q.ss_applied;

endmodule

// >>> link_deser_chk.sv
// Port checker for the link deserializer.
// Assumes it is bound into link_deser; sees its pins only.
`timescale 1ns/100ps
module link_deser_chk
  import deser_pkg::*;
(
  // Clock and bus
  input wire logic        CLOCK_IN,
  input wire logic        ARST_N_IN,
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [7:0]  WB_ADR_IN,
  input wire logic [3:0]  WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  // Link outputs
  input wire logic [17:0] VIDEO_WORD_OUT,
  input wire logic [8:0]  CTRL_WORD_OUT,
  input wire logic        PHASE_FLAG_OUT,
  input wire logic        LOCK_N_OUT,
  input wire logic        PCLK_OUT,
  input wire logic        DATA_OE_OUT,
  input wire logic        LOCK_OE_OUT,
  input wire logic        FAST_EDGE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  logic req, wr_ctrl, rng_q;
  assign req = WB_CYC_IN && WB_STB_IN;
  assign wr_ctrl = req && WB_WE_IN && WB_ACK_OUT && WB_SEL_IN[0]
                   && WB_ADR_IN == CTRL_OFS;
  // Keep the range bit of the accepted write; the bus is gone after ack
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN) rng_q <= 1'b0;
    else if (wr_ctrl) rng_q <= WB_DAT_IN[2];
  sequence take_s; req && !WB_ACK_OUT; endsequence
  sequence ack_s; WB_ACK_OUT ##1 !WB_ACK_OUT; endsequence
  sequence pd_s; wr_ctrl && !WB_DAT_IN[0]; endsequence
  ack_single_a: assert property (take_s |=> ack_s)
    else $error("bus ack not a single pulse");
  unmapped_zero_a: assert property (req && !WB_WE_IN && WB_ACK_OUT
    && WB_ADR_IN != CTRL_OFS && WB_ADR_IN != STATUS_OFS |-> WB_DAT_OUT == 0)
    else $error("unmapped read not zero");
  range_edge_a: assert property (
    wr_ctrl |-> ##[1:2] FAST_EDGE_OUT == rng_q)
    else $error("edge speed not from range");
  powerdown_hiz_a: assert property (
    pd_s |-> ##[1:2] !DATA_OE_OUT && !LOCK_OE_OUT)
    else $error("power-down left outputs driven");
  oe_pair_a: assert property (!LOCK_OE_OUT |-> !DATA_OE_OUT)
    else $error("data driven while lock released");
  wake_state_a: assert property ($rose(LOCK_OE_OUT) |-> LOCK_N_OUT
    && VIDEO_WORD_OUT == 0 && CTRL_WORD_OUT == 0 && !PHASE_FLAG_OUT)
    else $error("wake-up outputs wrong");
  unlocked_quiet_a: assert property (
    LOCK_N_OUT && $past(LOCK_N_OUT) |-> VIDEO_WORD_OUT == 0
    && CTRL_WORD_OUT == 0 && !PHASE_FLAG_OUT)
    else $error("outputs active while unlocked");
  video_hold_a: assert property (!PHASE_FLAG_OUT
    && !$past(PHASE_FLAG_OUT) && !LOCK_N_OUT && !$past(LOCK_N_OUT)
    |-> $stable(VIDEO_WORD_OUT))
    else $error("video changed in control phase");
  ctrl_hold_a: assert property (PHASE_FLAG_OUT
    && $past(PHASE_FLAG_OUT)
    && !LOCK_N_OUT && !$past(LOCK_N_OUT) |-> $stable(CTRL_WORD_OUT))
    else $error("control changed in video phase");
  pclk_glitch_a: assert property ($changed(PCLK_OUT)
    |=> $stable(PCLK_OUT) [*4])
    else $error("parallel clock pulse cut short");
endmodule
bind link_deser link_deser_chk u_chk (
  .CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN), .WB_CYC_IN(WB_CYC_IN),
  .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
  .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT),
  .WB_ACK_OUT(WB_ACK_OUT), .VIDEO_WORD_OUT(VIDEO_WORD_OUT),
  .CTRL_WORD_OUT(CTRL_WORD_OUT), .PHASE_FLAG_OUT(PHASE_FLAG_OUT),
  .LOCK_N_OUT(LOCK_N_OUT), .PCLK_OUT(PCLK_OUT), .DATA_OE_OUT(DATA_OE_OUT),
  .LOCK_OE_OUT(LOCK_OE_OUT), .FAST_EDGE_OUT(FAST_EDGE_OUT));

// >>> link_ser_model.sv
// Serializer stand-in: shifts 20-bit words out, one bit per clock.
// Assumes the bench supplies each word before the model takes it.
`timescale 1ns/100ps
module link_ser_model (
  // Bench side
  input  wire logic        clk_in,
  input  wire logic        en_in,
  input  wire logic [19:0] word_in,
  // Line side
  output logic             ser_out,
  output logic             take_out
);
  logic [19:0] sh;
  int          pos;
  initial begin
    ser_out = 1'b0;
    take_out = 1'b0;
    sh = 20'h00000;
    pos = 0;
  end
  // Whole words, bit 0 first; a disabled line holds still to look idle
  always @(posedge clk_in) begin
    take_out <= 1'b0;
    if (en_in) begin
      ser_out <= (pos == 0) ? word_in[0] : sh[pos];
      if (pos == 0) begin
        sh <= word_in;
        take_out <= 1'b1;
      end
      pos <= (pos == 19) ? 0 : pos + 1;
    end
  end
endmodule

// >>> link_deser_bench.sv
// Self-checking bench for the link deserializer.
// Assumes the serializer model and the checker are compiled first.
`timescale 1ns/100ps
module link_deser_bench
  import deser_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, ref_clk = 1'b0, en = 1'b1, ser, take;
  logic        ack, phase, lock_n, data_oe, lock_oe, fast;
  logic        pclk, wide, lock2_n;
  logic [2:0]  ref_h = 3'h0;
  logic [8:0]  tri_o;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, rv, seed = 32'h32;
  logic [19:0] word = TRANS_WORD_DEF;
  logic [17:0] video, v;
  logic [8:0]  ctrl, c;
  int          n_errors = 0, n_checks = 0, tick = 0, rcnt = 0, i, k;
  int          gap = 0;
  always #20 clk = ~clk;
  link_deser #(.REF_LOCK_CYC(8), .TIMEOUT_CYC(64), .HOLD_CYC(40)) DUT (
    .CLOCK_IN(clk), .ARST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rd), .WB_ACK_OUT(ack), .SERIAL_DATA_IN(ser),
    .LOCAL_REF_CLK_IN(ref_clk), .VIDEO_WORD_OUT(video),
    .CTRL_WORD_OUT(ctrl), .PHASE_FLAG_OUT(phase), .LOCK_N_OUT(lock_n),
    .PCLK_OUT(pclk), .DATA_OE_OUT(data_oe), .LOCK_OE_OUT(lock_oe),
    .FAST_EDGE_OUT(fast), .SPREAD_TRI_OUT(tri_o), .SPREAD_WIDE_OUT(wide));
  // Spread variant on the same bus and line; its lock output is compared
  link_deser #(.SPREAD_VARIANT(1'b1), .REF_LOCK_CYC(8), .TIMEOUT_CYC(64),
    .HOLD_CYC(40)) DUT_SS (
    .CLOCK_IN(clk), .ARST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(), .WB_ACK_OUT(), .SERIAL_DATA_IN(ser),
    .LOCAL_REF_CLK_IN(ref_clk), .VIDEO_WORD_OUT(), .CTRL_WORD_OUT(),
    .PHASE_FLAG_OUT(), .LOCK_N_OUT(lock2_n), .PCLK_OUT(), .DATA_OE_OUT(),
    .LOCK_OE_OUT(), .FAST_EDGE_OUT(), .SPREAD_TRI_OUT(),
    .SPREAD_WIDE_OUT());
  link_ser_model MODEL (.clk_in(clk), .en_in(en), .word_in(word),
    .ser_out(ser), .take_out(take));
  // Reference at the serializer word rate, 20 bit clocks a period
  always @(posedge clk) begin
    rcnt <= (rcnt == 9) ? 0 : rcnt + 1;
    ref_h <= {ref_h[1:0], ref_clk};
    if (rcnt == 9) ref_clk <= ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Control word with bit p of the tripled field inverted
  function automatic logic [19:0] enc_c(input logic [8:0] cw, input int p);
    logic [19:0] w;
    w = {cw[8:5], {3{cw[4]}}, {3{cw[3]}}, {3{cw[2]}}, {3{cw[1]}},
         {3{cw[0]}}, 1'b0};
    w[p] = ~w[p];
    return w;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(32'(ack), 32'h1);
    rv = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Three loads of one word, then room for the output pipeline
  task automatic send(input logic [19:0] w);
    word <= w;
    repeat (3) begin
      @(posedge clk);
      while (take !== 1'b1) @(posedge clk);
    end
    repeat (25) @(posedge clk);
  endtask
  task automatic lock_wait();
    int n;
    n = 0;
    while (lock_n !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(lock_n), 32'h0);
  endtask
  always @(posedge clk) begin
    tick <= tick + 1;
    // Cycles the spread variant lags behind the plain one in locking
    if (lock_n === 1'b0 && lock2_n === 1'b1) gap <= gap + 1;
    if (tick == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(lock_n), 32'h1);
    chk(32'(lock_oe), 32'h0);
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(rv, 32'(CTRL_RESET));
    wb(1'b0, 8'h08, 32'h0);
    chk(rv, 32'h0);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, CTRL_OFS, 32'(i << 1));
      repeat (2) @(posedge clk);
      chk(32'(fast), 32'(i >> 1));
    end
    $display("register test done");
    wb(1'b1, CTRL_OFS, 32'h7);
    repeat (2) @(posedge clk);
    chk(32'(lock_oe), 32'h1);
    chk(32'(lock_n), 32'h1);
    // Reference passes two sync stages and the output register
    repeat (20) begin
      @(posedge clk);
      chk(32'(pclk), 32'(ref_h[2]));
    end
    lock_wait();
    chk(32'(lock2_n), 32'h1);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(rv & 32'h71, 32'h40);
    $display("lock test done");
    for (k = 0; k < 10; k++) begin
      v = (k == 0) ? 18'h3FFFF : 18'(rnd());
      c = (k == 0) ? 9'h000 : 9'(rnd());
      if (c == 9'h1F8) c = 9'h1F9;
      send({v ^ {18{k[0]}}, k[0], 1'b1});
      chk(32'(video), 32'(v));
      chk(32'(phase), 32'h1);
      send(enc_c(c, 1 + int'(rnd() % 15)));
      chk(32'(ctrl), 32'(c));
      chk(32'(phase), 32'h0);
      chk(32'(video), 32'(v));
    end
    $display("traffic test done");
    chk({23'h0, wide, tri_o}, 32'h0);
    k = 0;
    while (lock2_n !== 1'b0 && k < 8000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(gap), 32'(SS_WAIT_CYC * WORD_BITS));
    $display("spread lock test done");
    en <= 1'b0;
    repeat (150) @(posedge clk);
    chk(32'(lock_n), 32'h1);
    chk(32'(video), 32'h0);
    chk(32'(ctrl), 32'h0);
    repeat (20) begin
      @(posedge clk);
      chk(32'(pclk), 32'(ref_h[2]));
    end
    en <= 1'b1;
    word <= TRANS_WORD_DEF;
    lock_wait();
    $display("idle test done");
    wb(1'b1, CTRL_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(data_oe), 32'h0);
    chk(32'(lock_oe), 32'h0);
    $display("power-down test done");
    report_and_stop();
  end
endmodule
